// ### motion_sequence_table_tb.sv
// Self-checking bench of the motion sequence table
`timescale 1ns/1ns
module motion_sequence_table_tb import mst_pkg::*;;
	logic        CLK_IN = 1'b0;
	logic        RST_IN = 1'b1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000, seed = 32'h00003202;
	logic        awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, slow = 0;
	logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, reached, mv;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, pos;
	logic [15:0] spd, mspd, mode;
	logic [33:0] wq[$], rq[$];
	logic [31:0] tgt[16];
	int          error_cnt = 0, comparisons = 0, cyc = 0, n_int = 0;
	always #5 CLK_IN = ~CLK_IN;
	mst_sequencer #(.MS_CYCLES(10)) dut_u (.CLK_IN(CLK_IN),
		.RST_IN(RST_IN), .S_AXI_AWADDR_IN(awaddr),
		.S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(aw_rdy),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF),
		.S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(w_rdy),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(b_vld),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
		.S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(ar_rdy),
		.S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(r_vld), .S_AXI_RREADY_IN(rready),
		.TARGET_REACHED_IN(reached), .RAMP_SPEED_IN(spd),
		.POS_CMD_OUT(pos), .MOVE_START_OUT(mv),
		.INTERP_ACTIVE_OUT(), .MAX_SPEED_OUT(mspd),
		.ACC_MAX_OUT(), .DEC_MAX_OUT(), .MODE_OUT(mode));
	mst_ramp_model ramp_u (.clk_in(CLK_IN), .rst_in(RST_IN),
		.move_start_in(mv), .slow_in(slow), .max_speed_in(mspd),
		.reached_out(reached), .speed_out(spd));
	task end_sim();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [11:0] ad(input logic [9:0] i);
		return {i, 2'b00};
	endfunction
	// Master holds each channel until its own handshake edge
	task wr(input logic [9:0] i, input logic [31:0] d,
		input logic [1:0] r = RESP_OKAY);
		logic ta, tw, tb;
		wq.push_back({32'h0, r});
		@(posedge CLK_IN);
		awaddr <= ad(i);
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge CLK_IN);
			ta = awvalid & aw_rdy;
			tw = wvalid & w_rdy;
			tb = b_vld;
			@(posedge CLK_IN);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end while (!tb);
	endtask
	task rd(input logic [9:0] i, input logic [33:0] e);
		logic ta, tr;
		rq.push_back(e);
		@(posedge CLK_IN);
		araddr <= ad(i);
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge CLK_IN);
			ta = arvalid & ar_rdy;
			tr = r_vld;
			@(posedge CLK_IN);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end while (!tr);
	endtask
	// Monitor takes the oldest note at each answer
	always @(negedge CLK_IN) begin
		if (b_vld && bready)
			chk({32'h0, bresp}, wq.pop_front());
		if (r_vld && rready)
			chk({rresp, rdata}, rq.pop_front());
		if (dut_u.INTERP_ACTIVE_OUT === 1'b1)
			n_int++;
	end
	always @(posedge CLK_IN) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			end_sim();
		end
	end
	// One sequence: entry i runs, entry i+1 holds time zero
	task seq(input logic [15:0] md, input logic [15:0] ctl,
		input logic [15:0] t, input logic [3:0] i, input logic sl,
		input int lo, input int hi, input logic [31:0] ep);
		int c, n0;
		logic [3:0] nx;
		nx = i + 4'h1;
		@(posedge CLK_IN);
		slow <= sl;
		wr(IDX_CTRL, {16'h0, ctl});
		wr(IDX_TIME_BASE + 10'(i), {16'h0, t});
		wr(IDX_TIME_BASE + 10'(nx), 32'h0);
		wr(IDX_INDEX, {28'h0, i});
		n0 = n_int;
		wr(IDX_MODE, {16'h0, md});
		c = 0;
		while (mode !== MODE_DONE && c < 20000) begin
			@(negedge CLK_IN);
			c++;
		end
		chk(c >= lo && c <= hi, 1'b1);
		chk(pos, ep);
		chk(n_int > n0, md == MODE_INTERP);
		rd(IDX_INDEX, {RESP_OKAY, 28'h0, nx});
		rd(IDX_MODE, {RESP_OKAY, 16'h0, MODE_DONE});
		$display("sequence from entry %0d done", i);
	endtask
	initial begin
		repeat (8) @(posedge CLK_IN);
		RST_IN <= 1'b0;
		rd(IDX_MODE, {RESP_OKAY, 32'h0});
		rd(IDX_CTRL, {RESP_OKAY, 32'h0});
		rd(IDX_INDEX, {RESP_OKAY, 32'h0});
		rd(10'h000, {RESP_SLVERR, 32'h0});
		wr(10'h000, 32'h1234, RESP_SLVERR);
		wr(IDX_RAMP_SPD, 32'h5555);
		rd(IDX_RAMP_SPD, {RESP_OKAY, 32'h0});
		wr(IDX_SPD_MAX, 32'h00000C80);
		rd(IDX_SPD_MAX, {RESP_OKAY, 32'h00000C80});
		chk(mspd, 16'h0C80);
		$display("register test done");
		for (int n = 0; n < 16; n++) begin
			tgt[n] = xs();
			wr(IDX_TGT_BASE + 10'(n), tgt[n]);
			wr(IDX_TIME_BASE + 10'(n), 32'h2);
		end
		for (int n = 0; n < 16; n++)
			rd(IDX_TGT_BASE + 10'(n), {RESP_OKAY, tgt[n]});
		$display("table test done");
		seq(MODE_RAMP, 16'h0000, 3, 0, 0, 15, 45, tgt[0]);
		seq(MODE_RAMP, 16'h0001, 3, 2, 1, 300, 370, tgt[2]);
		seq(MODE_RAMP, 16'h0000, 3, 6, 1, 15, 45, tgt[6]);
		seq(MODE_INTERP, 16'h0004, 3, 9, 0, 15, 45, tgt[10]);
		wr(IDX_TGT_BASE + 10'h9, tgt[3]);
		rd(IDX_TGT_BASE + 10'h9, {RESP_OKAY, tgt[3]});
		seq(MODE_RAMP, 16'h0004, 1, 15, 0, 9980, 10040, tgt[15]);
		// Mode change mid-entry must freeze the index
		wr(IDX_CTRL, 32'h0);
		wr(IDX_TIME_BASE + 10'h4, 32'h5);
		wr(IDX_INDEX, 32'h4);
		wr(IDX_MODE, {16'h0, MODE_RAMP});
		wr(IDX_MODE, 32'h0);
		repeat (200) @(posedge CLK_IN);
		chk(mode, 16'h0000);
		rd(IDX_INDEX, {RESP_OKAY, 32'h4});
		$display("mode change test done");
		wr(IDX_CTRL, 32'h10);
		wr(IDX_TIME_BASE + 10'h5, 32'h0);
		wr(IDX_INDEX, 32'h5);
		wr(IDX_MODE, {16'h0, MODE_RAMP});
		repeat (300) @(negedge CLK_IN);
		chk(mode, MODE_RAMP);
		wr(IDX_MODE, 32'h0);
		$display("repeat test done");
		end_sim();
	end
endmodule // motion_sequence_table_tb

// ### mst_entry_timer.sv
// Entry delay timer counting in the selected unit
`timescale 1ns/1ns
module mst_entry_timer import mst_pkg::*; (
	input  wire logic CLK_IN,
	input  wire logic RST_IN,
	mst_timer_if.tmr  tif
);
	logic        active_r;
	logic [15:0] cnt_r;
	logic [15:0] unit_r;
	logic [15:0] ulen_r;
	// Unit length in milliseconds
	wire logic [15:0] ulen = (tif.scale == SCALE_S)   ? UNIT_S_LEN :
	                         (tif.scale == SCALE_MIN) ? UNIT_MIN_LEN :
	                                                    UNIT_MS_LEN;
	wire logic        unit_done = tif.ms_tick & (unit_r == ulen_r - 16'h0001);

	// First unit may be short by up to one tick phase
	assign tif.expired = active_r & (cnt_r == 16'h0000);
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			active_r <= 1'b0;
			cnt_r    <= 16'h0000;
			unit_r   <= 16'h0000;
			ulen_r   <= UNIT_MS_LEN;
		end else if (tif.start) begin
			active_r <= 1'b1;
			cnt_r    <= tif.load;
			unit_r   <= 16'h0000;
			ulen_r   <= ulen;
		end else if (tif.expired) begin
			active_r <= 1'b0;
		end else if (active_r && tif.ms_tick) begin
			unit_r <= unit_done ? 16'h0000 : unit_r + 16'h0001;
			if (unit_done)
				cnt_r <= cnt_r - 16'h0001;
		end
	end
endmodule // mst_entry_timer

// ### mst_pkg.sv
// Package: register map, encodings and timing of the motion sequence table
package mst_pkg;
	localparam int          N_ENTRIES     = 16;
	localparam int          POS_PER_REV   = 4096;
	localparam int          ADDR_W        = 12;
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          MS_PERIOD_NS  = 1000000;
	localparam int          MS_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [15:0] UNIT_MS_LEN   = 16'h0001;
	localparam logic [15:0] UNIT_S_LEN    = 16'h03E8;
	localparam logic [15:0] UNIT_MIN_LEN  = 16'hEA60;
	localparam logic [9:0]  IDX_RAMP_SPD  = 10'h15E;
	localparam logic [9:0]  IDX_SPD_MAX   = 10'h15F;
	localparam logic [9:0]  IDX_ACC_MAX   = 10'h161;
	localparam logic [9:0]  IDX_DEC_MAX   = 10'h162;
	localparam logic [9:0]  IDX_MODE      = 10'h190;
	localparam logic [9:0]  IDX_CTRL      = 10'h1F4;
	localparam logic [9:0]  IDX_INDEX     = 10'h1F5;
	localparam logic [9:0]  IDX_TGT_BASE  = 10'h1FE;
	localparam logic [9:0]  IDX_TIME_BASE = 10'h23A;
	localparam int          CTRL_DELAY    = 0;
	localparam int          CTRL_SCALE_LO = 2;
	localparam int          CTRL_REPEAT   = 4;
	localparam logic [1:0]  SCALE_MS      = 2'h0;
	localparam logic [1:0]  SCALE_S       = 2'h1;
	localparam logic [1:0]  SCALE_MIN     = 2'h2;
	localparam logic [15:0] MODE_RAMP     = 16'h0032;
	localparam logic [15:0] MODE_INTERP   = 16'h0033;
	localparam logic [15:0] MODE_DONE     = 16'h0036;
	localparam logic [15:0] RST_MODE      = 16'h0000;
	localparam logic [15:0] RST_CTRL      = 16'h0000;
	localparam logic [15:0] RST_LIMIT     = 16'h0000;
	localparam logic [3:0]  RST_INDEX     = 4'h0;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	typedef enum logic [4:0] {
		MST_S_IDLE   = 5'h01,
		MST_S_LOAD   = 5'h02,
		MST_S_REACH  = 5'h04,
		MST_S_TIME   = 5'h08,
		MST_S_INTERP = 5'h10
	} mst_state_t;
endpackage

// ### mst_ramp_model.sv
// Behavioural ramp generator facing the sequencer
`timescale 1ns/1ns
module mst_ramp_model #(
	parameter int SLOW_CYC = 300
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        move_start_in,
	input  wire logic        slow_in,
	input  wire logic [15:0] max_speed_in,
	output wire logic        reached_out,
	output wire logic [15:0] speed_out
);
	logic [15:0] cnt_r;
	logic        reached_r;
	// Slow mode lets the entry timer beat arrival
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r     <= 16'h0000;
			reached_r <= 1'b1;
		end else if (move_start_in) begin
			cnt_r     <= slow_in ? 16'(SLOW_CYC) : 16'h0004;
			reached_r <= 1'b0;
		end else if (cnt_r != 16'h0000) begin
			cnt_r     <= cnt_r - 16'h0001;
			reached_r <= (cnt_r == 16'h0001);
		end
	end
	assign reached_out = reached_r;
	assign speed_out   = reached_r ? 16'h0000 : max_speed_in;
endmodule // mst_ramp_model

// ### mst_sequencer.sv
// Motion sequence table with AXI4-Lite register access
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
module mst_sequencer import mst_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	input  wire logic              CLK_IN,
	input  wire logic              RST_IN,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
	input  wire logic              S_AXI_AWVALID_IN,
	output wire logic              S_AXI_AWREADY_OUT,
	input  wire logic [31:0]       S_AXI_WDATA_IN,
	input  wire logic [3:0]        S_AXI_WSTRB_IN,
	input  wire logic              S_AXI_WVALID_IN,
	output wire logic              S_AXI_WREADY_OUT,
	output wire logic [1:0]        S_AXI_BRESP_OUT,
	output wire logic              S_AXI_BVALID_OUT,
	input  wire logic              S_AXI_BREADY_IN,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
	input  wire logic              S_AXI_ARVALID_IN,
	output wire logic              S_AXI_ARREADY_OUT,
	output wire logic [31:0]       S_AXI_RDATA_OUT,
	output wire logic [1:0]        S_AXI_RRESP_OUT,
	output wire logic              S_AXI_RVALID_OUT,
	input  wire logic              S_AXI_RREADY_IN,
	input  wire logic              TARGET_REACHED_IN,
	input  wire logic [15:0]       RAMP_SPEED_IN,
	output wire logic [31:0]       POS_CMD_OUT,
	output wire logic              MOVE_START_OUT,
	output wire logic              INTERP_ACTIVE_OUT,
	output wire logic [15:0]       MAX_SPEED_OUT,
	output wire logic [15:0]       ACC_MAX_OUT,
	output wire logic [15:0]       DEC_MAX_OUT,
	output wire logic [15:0]       MODE_OUT
);
	mst_state_t  st_r;
	mst_state_t  st_nxt;
	logic [15:0] mode_r;
	logic [15:0] ctrl_r;
	logic [3:0]  idx_r;
	logic [15:0] spd_max_r;
	logic [15:0] acc_max_r;
	logic [15:0] dec_max_r;
	logic [31:0] tgt_r [N_ENTRIES];
	logic [15:0] time_r [N_ENTRIES];
	logic [31:0] pos_cmd_r;
	logic [31:0] end_r;
	logic [32:0] dmag_r;
	logic        dir_r;
	logic [15:0] dur_r;
	logic [33:0] acc_r;
	logic        move_start_r;
	logic                  aw_held_r;
	logic                  w_held_r;
	logic [ADDR_W-1:0]     aw_addr_r;
	logic [31:0]           w_data_r;
	logic [3:0]            w_strb_r;
	logic                  bvalid_r;
	logic [1:0]            bresp_r;
	logic                  rvalid_r;
	logic [31:0]           rdata_r;
	logic [1:0]            rresp_r;

	mst_timer_if tif ();
	mst_tick_gen #(.MS_CYCLES(MS_CYCLES)) u_tick (
		.CLK_IN (CLK_IN),
		.RST_IN (RST_IN),
		.tif    (tif)
	);
	mst_entry_timer u_timer (
		.CLK_IN (CLK_IN),
		.RST_IN (RST_IN),
		.tif    (tif)
	);

	function automatic logic tbl_hit(input logic [9:0] ix,
		input logic [9:0] base);
		return (ix >= base) && (ix < base + 10'h010);
	endfunction
	function automatic logic [3:0] tbl_ent(input logic [9:0] ix,
		input logic [9:0] base);
		return 4'(ix - base);
	endfunction
	function automatic logic reg_hit(input logic [9:0] ix);
		return (ix == IDX_MODE) || (ix == IDX_CTRL) || (ix == IDX_INDEX) ||
			(ix == IDX_RAMP_SPD) || (ix == IDX_SPD_MAX) ||
			(ix == IDX_ACC_MAX) || (ix == IDX_DEC_MAX) ||
			tbl_hit(ix, IDX_TGT_BASE) || tbl_hit(ix, IDX_TIME_BASE);
	endfunction
	function automatic logic [31:0] read_reg(input logic [9:0] ix);
		logic [31:0] v;
		v = 32'h00000000;
		if (ix == IDX_MODE)
			v = {16'h0000, mode_r};
		else if (ix == IDX_CTRL)
			v = {16'h0000, ctrl_r};
		else if (ix == IDX_INDEX)
			v = {28'h0000000, idx_r};
		else if (ix == IDX_RAMP_SPD)
			v = {16'h0000, RAMP_SPEED_IN};
		else if (ix == IDX_SPD_MAX)
			v = {16'h0000, spd_max_r};
		else if (ix == IDX_ACC_MAX)
			v = {16'h0000, acc_max_r};
		else if (ix == IDX_DEC_MAX)
			v = {16'h0000, dec_max_r};
		else if (tbl_hit(ix, IDX_TGT_BASE))
			v = tgt_r[tbl_ent(ix, IDX_TGT_BASE)];
		else if (tbl_hit(ix, IDX_TIME_BASE))
			v = {16'h0000, time_r[tbl_ent(ix, IDX_TIME_BASE)]};
		return v;
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] v;
		v = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				v[b*8 +: 8] = nw[b*8 +: 8];
		return v;
	endfunction

	// Bus write path: address and data are taken in either order
	wire logic [9:0]  wr_ix   = aw_addr_r[ADDR_W-1:2];
	wire logic [9:0]  rd_ix   = S_AXI_ARADDR_IN[ADDR_W-1:2];
	wire logic        do_wr   = aw_held_r & w_held_r & ~bvalid_r;
	wire logic [31:0] wr_val  = merge(read_reg(wr_ix), w_data_r, w_strb_r);
	wire logic        wr_mode = do_wr & (wr_ix == IDX_MODE);
	wire logic        wr_idx  = do_wr & (wr_ix == IDX_INDEX);
	wire logic        wr_tgt  = do_wr & tbl_hit(wr_ix, IDX_TGT_BASE);
	wire logic        wr_time = do_wr & tbl_hit(wr_ix, IDX_TIME_BASE);
	wire logic        rd_take = S_AXI_ARVALID_IN & ~rvalid_r;

	// Sequencer decode
	wire logic        is_ramp   = (mode_r == MODE_RAMP);
	wire logic        is_interp = (mode_r == MODE_INTERP);
	wire logic        mode_chg  = wr_mode & (wr_val[15:0] != mode_r);
	wire logic        delay_on  = ctrl_r[CTRL_DELAY];
	wire logic        repeat_on = ctrl_r[CTRL_REPEAT];
	wire logic [3:0]  idx_inc   = idx_r + 4'h1;
	wire logic [31:0] cur_tgt   = tgt_r[idx_r];
	wire logic [31:0] nxt_tgt   = tgt_r[idx_inc];
	wire logic [15:0] cur_time  = time_r[idx_r];
	wire logic        in_load   = (st_r == MST_S_LOAD) & ~mode_chg;
	wire logic        zero_stop = in_load & (cur_time == 16'h0000) &
	                              ~repeat_on;
	wire logic        go_entry  = in_load & ~zero_stop;
	// Old arrival level still stands while the start pulse is out
	wire logic        reach_go  = (st_r == MST_S_REACH) & TARGET_REACHED_IN &
	                              ~move_start_r & ~mode_chg;
	wire logic        in_interp = (st_r == MST_S_INTERP);
	wire logic        adv       = ((st_r == MST_S_TIME) | in_interp) &
	                              tif.expired & ~mode_chg;
	wire logic [32:0] diff      = {nxt_tgt[31], nxt_tgt} -
	                              {cur_tgt[31], cur_tgt};
	wire logic        step      = in_interp & (dur_r != 16'h0000) &
	                              (acc_r >= {18'h00000, dur_r});
	wire logic [33:0] acc_add   = tif.ms_tick ? {1'b0, dmag_r} : 34'h0;
	wire logic [33:0] acc_sub   = step ? {18'h00000, dur_r} : 34'h0;

	// Timer starts with the move, or on arrival when the delay bit is set in ramp mode
	assign tif.start = (go_entry & (is_interp | ~delay_on)) | reach_go;
	assign tif.scale = is_interp ? SCALE_MS :
	                   ctrl_r[CTRL_SCALE_LO +: 2];
	assign tif.load  = cur_time;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			MST_S_IDLE: begin
				if (is_ramp || is_interp)
					st_nxt = MST_S_LOAD;
			end
			MST_S_LOAD: begin
				if (zero_stop)
					st_nxt = MST_S_IDLE;
				else if (is_interp)
					st_nxt = MST_S_INTERP;
				else if (delay_on)
					st_nxt = MST_S_REACH;
				else
					st_nxt = MST_S_TIME;
			end
			MST_S_REACH: begin
				if (reach_go)
					st_nxt = MST_S_TIME;
			end
			MST_S_TIME: begin
				if (tif.expired)
					st_nxt = MST_S_LOAD;
			end
			MST_S_INTERP: begin
				if (tif.expired)
					st_nxt = MST_S_LOAD;
			end
			default: st_nxt = MST_S_IDLE;
		endcase
		if (mode_chg)
			st_nxt = MST_S_IDLE;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_r   <= MST_S_IDLE;
			mode_r <= RST_MODE;
			idx_r  <= RST_INDEX;
		end else begin
			st_r <= st_nxt;
			// Software write beats the finished marker in one cycle
			if (wr_mode)
				mode_r <= wr_val[15:0];
			else if (zero_stop)
				mode_r <= MODE_DONE;
			if (wr_idx)
				idx_r <= wr_val[3:0];
			else if (adv)
				idx_r <= idx_inc;
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ctrl_r    <= RST_CTRL;
			spd_max_r <= RST_LIMIT;
			acc_max_r <= RST_LIMIT;
			dec_max_r <= RST_LIMIT;
		end else if (do_wr) begin
			if (wr_ix == IDX_CTRL)
				ctrl_r <= wr_val[15:0];
			if (wr_ix == IDX_SPD_MAX)
				spd_max_r <= wr_val[15:0];
			if (wr_ix == IDX_ACC_MAX)
				acc_max_r <= wr_val[15:0];
			if (wr_ix == IDX_DEC_MAX)
				dec_max_r <= wr_val[15:0];
		end
	end

	// Entry table in flip-flops
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			for (int i = 0; i < N_ENTRIES; i++) begin
				tgt_r[i]  <= 32'h00000000;
				time_r[i] <= 16'h0000;
			end
		end else begin
			if (wr_tgt)
				tgt_r[tbl_ent(wr_ix, IDX_TGT_BASE)] <= wr_val;
			if (wr_time)
				time_r[tbl_ent(wr_ix, IDX_TIME_BASE)] <= wr_val[15:0];
		end
	end

	// Position command; interpolation by error accumulation per tick.
	// Slope must stay below one count per clock, far above real speeds.
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pos_cmd_r    <= 32'h00000000;
			end_r        <= 32'h00000000;
			dmag_r       <= 33'h000000000;
			dir_r        <= 1'b0;
			dur_r        <= 16'h0000;
			acc_r        <= 34'h000000000;
			move_start_r <= 1'b0;
		end else begin
			move_start_r <= go_entry & is_ramp;
			if (go_entry) begin
				pos_cmd_r <= cur_tgt;
				end_r     <= nxt_tgt;
				dir_r     <= diff[32];
				dmag_r    <= diff[32] ? 33'h000000000 - diff : diff;
				dur_r     <= cur_time;
				acc_r     <= 34'h000000000;
			end else if (in_interp && tif.expired) begin
				pos_cmd_r <= end_r;
			end else if (in_interp) begin
				acc_r <= acc_r + acc_add - acc_sub;
				if (step)
					pos_cmd_r <= dir_r ? pos_cmd_r - 32'h00000001 :
						pos_cmd_r + 32'h00000001;
			end
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_IN && !aw_held_r) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR_IN;
			end else if (do_wr)
				aw_held_r <= 1'b0;
			if (S_AXI_WVALID_IN && !w_held_r) begin
				w_held_r <= 1'b1;
				w_data_r <= S_AXI_WDATA_IN;
				w_strb_r <= S_AXI_WSTRB_IN;
			end else if (do_wr)
				w_held_r <= 1'b0;
			if (do_wr) begin
				bvalid_r <= 1'b1;
				bresp_r  <= reg_hit(wr_ix) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY_IN)
				bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= RESP_OKAY;
		end else if (rd_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= read_reg(rd_ix);
			rresp_r  <= reg_hit(rd_ix) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY_IN)
			rvalid_r <= 1'b0;
	end

	assign S_AXI_AWREADY_OUT = ~aw_held_r;
	assign S_AXI_WREADY_OUT  = ~w_held_r;
	assign S_AXI_BVALID_OUT  = bvalid_r;
	assign S_AXI_BRESP_OUT   = bresp_r;
	assign S_AXI_ARREADY_OUT = ~rvalid_r;
	assign S_AXI_RVALID_OUT  = rvalid_r;
	assign S_AXI_RDATA_OUT   = rdata_r;
	assign S_AXI_RRESP_OUT   = rresp_r;
	assign POS_CMD_OUT       = pos_cmd_r;
	assign MOVE_START_OUT    = move_start_r;
	assign INTERP_ACTIVE_OUT = in_interp;
	assign MAX_SPEED_OUT     = spd_max_r;
	assign ACC_MAX_OUT       = acc_max_r;
	assign DEC_MAX_OUT       = dec_max_r;
	assign MODE_OUT          = mode_r;

	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	property p_inc;
		adv && !wr_idx && idx_r != 4'hF |=> idx_r == $past(idx_r) + 4'h1;
	endproperty
	a_inc: assert property (p_inc) else $error("index not incremented");
	property p_wrap;
		adv && !wr_idx && idx_r == 4'hF |=> idx_r == 4'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("index not wrapped");
	property p_done;
		zero_stop && !wr_mode |=> mode_r == MODE_DONE && st_r == MST_S_IDLE;
	endproperty
	a_done: assert property (p_done) else $error("no finished mode");
	property p_repeat;
		in_load && repeat_on && !wr_mode |=> st_r != MST_S_IDLE;
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat stopped");
	property p_abort;
		mode_chg |=> st_r == MST_S_IDLE && !tif.start;
	endproperty
	a_abort: assert property (p_abort) else $error("mode change ignored");
	property p_enter;
		st_r == MST_S_IDLE && (is_ramp || is_interp) && !mode_chg |=>
			st_r == MST_S_LOAD && idx_r == $past(idx_r);
	endproperty
	a_enter: assert property (p_enter) else $error("no sequence start");
	property p_move;
		go_entry && is_ramp |=> MOVE_START_OUT &&
			POS_CMD_OUT == $past(cur_tgt);
	endproperty
	a_move: assert property (p_move) else $error("ramped move missing");
	property p_delay0;
		go_entry && is_ramp && !delay_on |-> tif.start ##1
			st_r == MST_S_TIME;
	endproperty
	a_delay0: assert property (p_delay0) else $error("timer late");
	property p_delay1;
		go_entry && is_ramp && delay_on |-> !tif.start ##1
			st_r == MST_S_REACH;
	endproperty
	a_delay1: assert property (p_delay1) else $error("timer early");
	property p_interp_end;
		in_interp && tif.expired && !mode_chg |=>
			POS_CMD_OUT == $past(end_r);
	endproperty
	a_interp_end: assert property (p_interp_end) else $error("bad arrival");
	property p_scale;
		tif.start && is_interp |-> tif.scale == SCALE_MS;
	endproperty
	a_scale: assert property (p_scale) else $error("interp not in ms");
	c_ramp: cover property (adv && is_ramp);
	c_interp: cover property (adv && is_interp && idx_r == 4'hF);
	c_done: cover property (zero_stop);
	c_abort: cover property (mode_chg && st_r != MST_S_IDLE);
endmodule // mst_sequencer

// ### mst_tick_gen.sv
// Millisecond tick divider
`timescale 1ns/1ns
module mst_tick_gen #(
	parameter int MS_CYCLES = 100000
) (
	input  wire logic CLK_IN,
	input  wire logic RST_IN,
	mst_timer_if.gen  tif
);
	localparam int CW = $clog2(MS_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(MS_CYCLES - 1);
	logic [CW-1:0] cnt_r;
	wire logic     wrap = (cnt_r == LAST);

	assign tif.ms_tick = wrap;
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			cnt_r <= '0;
		else
			cnt_r <= wrap ? '0 : cnt_r + 1'b1;
	end
endmodule // mst_tick_gen

// ### mst_timer_if.sv
// Interface between sequencer, millisecond tick and entry timer
`timescale 1ns/1ns
interface mst_timer_if;
	logic        ms_tick;
	logic        start;
	logic [1:0]  scale;
	logic [15:0] load;
	logic        expired;
	modport gen (output ms_tick);
	modport tmr (input ms_tick, input start, input scale, input load,
		output expired);
	modport ctl (input ms_tick, input expired, output start,
		output scale, output load);
endinterface
